// ===== verilog/gpio_data_pkg.sv
/*
 * Constants for the general-purpose pin data port: register addresses, reset values,
 * register kinds and the address lookup used by the bus decoder.
 * Assumes a 32-bit byte-addressed APB bus with each register on one aligned word.
 */
// Behaviour
// - a write to an output-level word drives the written bit on each enabled output pin
// - for an input pin, writing its output-level bit leaves the pin undriven
// - reading an output-level word returns the last value written, any direction
// - reading an input-level word returns the live pin level for input pins
// - reading an input-level word returns the written output bit for output pins
// - three read/write output-level words, bit n serves pin n, reset zero
// - three read-only input-level words, bit n serves pin n, reset zero
// - set enable bit gives pin to general use, clear keeps primary function; reset zero
// - direction bit selects sense or drive; direction resets to all ones
package gpio_data_pkg;

	localparam int WORD_W = 32;
	localparam int NUM_WORDS = 3;

	localparam logic [31:0] ENABLE_ADDR0 = 32'hD00A0000;
	localparam logic [31:0] ENABLE_ADDR1 = 32'hD00A0004;
	localparam logic [31:0] ENABLE_ADDR2 = 32'hD00A0008;
	localparam logic [31:0] DIRECTION_ADDR0 = 32'hD00A000C;
	localparam logic [31:0] DIRECTION_ADDR1 = 32'hD00A0010;
	localparam logic [31:0] DIRECTION_ADDR2 = 32'hD00A0014;
	localparam logic [31:0] OUTPUT_LEVEL_ADDR0 = 32'hD00A0018;
	localparam logic [31:0] OUTPUT_LEVEL_ADDR1 = 32'hD00A001C;
	localparam logic [31:0] OUTPUT_LEVEL_ADDR2 = 32'hD00A0020;
	localparam logic [31:0] INPUT_LEVEL_ADDR0 = 32'hD00A0024;
	localparam logic [31:0] INPUT_LEVEL_ADDR1 = 32'hD00A0028;
	localparam logic [31:0] INPUT_LEVEL_ADDR2 = 32'hD00A002C;

	localparam logic [31:0] ENABLE_RESET = 32'h00000000;
	localparam logic [31:0] DIRECTION_RESET = 32'hFFFFFFFF;
	localparam logic [31:0] OUTPUT_LEVEL_RESET = 32'h00000000;
	localparam logic [31:0] INPUT_LEVEL_RESET = 32'h00000000;
	localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

	typedef enum logic [1:0]
	{
		KIND_ENABLE = 2'h0,
		KIND_DIRECTION = 2'h1,
		KIND_OUTPUT_LEVEL = 2'h2,
		KIND_INPUT_LEVEL = 2'h3
	} reg_kind_t;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'h0,
		ST_ACCESS = 2'h1
	} bus_state_t;

	// byte address of one register word of a given kind
	function automatic logic [31:0] reg_addr(input reg_kind_t kind, input logic [1:0] word);
		logic [31:0] a0;
		logic [31:0] a1;
		logic [31:0] a2;
		a0 = INPUT_LEVEL_ADDR0;
		a1 = INPUT_LEVEL_ADDR1;
		a2 = INPUT_LEVEL_ADDR2;
		case (kind)
			KIND_ENABLE:
			begin
				a0 = ENABLE_ADDR0;
				a1 = ENABLE_ADDR1;
				a2 = ENABLE_ADDR2;
			end
			KIND_DIRECTION:
			begin
				a0 = DIRECTION_ADDR0;
				a1 = DIRECTION_ADDR1;
				a2 = DIRECTION_ADDR2;
			end
			KIND_OUTPUT_LEVEL:
			begin
				a0 = OUTPUT_LEVEL_ADDR0;
				a1 = OUTPUT_LEVEL_ADDR1;
				a2 = OUTPUT_LEVEL_ADDR2;
			end
			default:
			begin
				a0 = INPUT_LEVEL_ADDR0;
				a1 = INPUT_LEVEL_ADDR1;
				a2 = INPUT_LEVEL_ADDR2;
			end
		endcase
		case (word)
			2'h0: return a0;
			2'h1: return a1;
			default: return a2;
		endcase
	endfunction

endpackage

// ===== verilog/gpio_pin_word.sv
/*
 * One 32-pin slice of the data port: enable, direction and output-level registers,
 * the registered pin drivers and the sampled input-level word.
 * Assumes the bus side hands it a qualified write pulse with byte strobes.
 */
`timescale 1ns/1ns
module gpio_pin_word #(
	parameter int W = gpio_data_pkg::WORD_W
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic wr_en_i,
	input wire gpio_data_pkg::reg_kind_t wr_kind_i,
	input wire logic [W-1:0] wdata_i,
	input wire logic [W/8-1:0] wstrb_i,
	input wire logic [W-1:0] pin_in_i,
	output logic [W-1:0] enable_o,
	output logic [W-1:0] direction_o,
	output logic [W-1:0] output_level_o,
	output logic [W-1:0] input_level_o,
	output logic [W-1:0] pin_out_o,
	output logic [W-1:0] pin_oe_o
);

	if (W % 8 != 0)
	begin : g_check
		$error("gpio_pin_word: W must be a whole number of bytes");
	end

	logic [W-1:0] byte_mask;
	logic [W-1:0] next_enable;
	logic [W-1:0] next_direction;
	logic [W-1:0] next_output_level;
	logic [W-1:0] next_input_level;
	logic [W-1:0] next_pin_out;
	logic [W-1:0] next_pin_oe;

	for (genvar b = 0; b < W / 8; b++)
	begin : g_mask
		assign byte_mask[b*8 +: 8] = {8{wstrb_i[b]}};
	end

	always_comb
	begin
		next_enable = enable_o;
		next_direction = direction_o;
		next_output_level = output_level_o;
		if (wr_en_i)
		begin
			case (wr_kind_i)
				gpio_data_pkg::KIND_ENABLE:
					next_enable = (enable_o & ~byte_mask) | (wdata_i & byte_mask);
				gpio_data_pkg::KIND_DIRECTION:
					next_direction = (direction_o & ~byte_mask) | (wdata_i & byte_mask);
				gpio_data_pkg::KIND_OUTPUT_LEVEL:
					// stored whatever the direction, so readback matches the write
					next_output_level = (output_level_o & ~byte_mask) | (wdata_i & byte_mask);
				default:
					next_output_level = output_level_o;
			endcase
		end
		// direction bit set means sense; output pins reflect their own stored level
		next_input_level = (next_direction & pin_in_i) | (~next_direction & next_output_level);
		next_pin_out = next_output_level;
		// only enabled pins set to drive get the driver; inputs ignore the level
		next_pin_oe = next_enable & ~next_direction;
	end

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			enable_o <= W'(gpio_data_pkg::ENABLE_RESET);
			direction_o <= W'(gpio_data_pkg::DIRECTION_RESET);
			output_level_o <= W'(gpio_data_pkg::OUTPUT_LEVEL_RESET);
			input_level_o <= W'(gpio_data_pkg::INPUT_LEVEL_RESET);
			pin_out_o <= W'(gpio_data_pkg::OUTPUT_LEVEL_RESET);
			pin_oe_o <= '0;
		end
		else
		begin
			enable_o <= next_enable;
			direction_o <= next_direction;
			output_level_o <= next_output_level;
			input_level_o <= next_input_level;
			pin_out_o <= next_pin_out;
			pin_oe_o <= next_pin_oe;
		end
	end

endmodule // gpio_pin_word

// ===== verilog/gpio_data_port.sv
/*
 * General-purpose pin data port: APB slave over the enable, direction,
 * output-level and input-level words, with one slice per 32 pins.
 * Assumes pins are synchronous to core_clk_i and a pad mux outside uses pin_sel_o.
 */
`timescale 1ns/1ns
module gpio_data_port #(
	parameter int NUM_WORDS = gpio_data_pkg::NUM_WORDS
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [31:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [NUM_WORDS*32-1:0] pin_in_i,
	output logic [NUM_WORDS*32-1:0] pin_out_o,
	output logic [NUM_WORDS*32-1:0] pin_oe_o,
	output logic [NUM_WORDS*32-1:0] pin_sel_o
);

	if (NUM_WORDS < 1 || NUM_WORDS > 3)
	begin : g_check
		$error("gpio_data_port: address map holds one to three words per kind");
	end

	localparam int PINS = NUM_WORDS * 32;

	gpio_data_pkg::bus_state_t state;
	gpio_data_pkg::bus_state_t next_state;
	logic next_pready;
	logic next_pslverr;
	logic [31:0] next_prdata;

	logic hit;
	logic [1:0] hit_word;
	gpio_data_pkg::reg_kind_t hit_kind;
	logic wr_en;
	logic [NUM_WORDS-1:0] word_wr;

	logic [PINS-1:0] enable_all;
	logic [PINS-1:0] direction_all;
	logic [PINS-1:0] output_level_all;
	logic [PINS-1:0] input_level_all;

	// one address compare table serves reads and writes alike
	always_comb
	begin
		hit = 1'b0;
		hit_word = 2'h0;
		hit_kind = gpio_data_pkg::KIND_ENABLE;
		for (int k = 0; k < 4; k++)
		begin
			for (int w = 0; w < NUM_WORDS; w++)
			begin
				if (paddr_i == gpio_data_pkg::reg_addr(gpio_data_pkg::reg_kind_t'(k), 2'(w)))
				begin
					hit = 1'b1;
					hit_word = 2'(w);
					hit_kind = gpio_data_pkg::reg_kind_t'(k);
				end
			end
		end
	end

	// write lands only at the completing edge; input-level words refuse writes
	always_comb
	begin
		wr_en = (state == gpio_data_pkg::ST_ACCESS) && psel_i && penable_i && pwrite_i
			&& pready_o && hit && (hit_kind != gpio_data_pkg::KIND_INPUT_LEVEL);
		for (int w = 0; w < NUM_WORDS; w++)
		begin
			word_wr[w] = wr_en && (hit_word == 2'(w));
		end
	end

	for (genvar g = 0; g < NUM_WORDS; g++)
	begin : g_word
		gpio_pin_word #(
			.W(32)
		) u_word (
			.core_clk_i(core_clk_i),
			.nrst_i(nrst_i),
			.wr_en_i(word_wr[g]),
			.wr_kind_i(hit_kind),
			.wdata_i(pwdata_i),
			.wstrb_i(pstrb_i),
			.pin_in_i(pin_in_i[g*32 +: 32]),
			.enable_o(enable_all[g*32 +: 32]),
			.direction_o(direction_all[g*32 +: 32]),
			.output_level_o(output_level_all[g*32 +: 32]),
			.input_level_o(input_level_all[g*32 +: 32]),
			.pin_out_o(pin_out_o[g*32 +: 32]),
			.pin_oe_o(pin_oe_o[g*32 +: 32])
		);
	end

	// pad mux select follows the stored enable bits directly
	assign pin_sel_o = enable_all;

	// zero wait states: pready rises in the first access cycle
	always_comb
	begin
		next_state = state;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		next_prdata = prdata_o;
		case (state)
			gpio_data_pkg::ST_IDLE:
			begin
				if (psel_i && !penable_i)
				begin
					next_state = gpio_data_pkg::ST_ACCESS;
					next_pready = 1'b1;
					next_prdata = gpio_data_pkg::UNMAPPED_READ;
					if (!hit)
					begin
						next_pslverr = 1'b1;
					end
					else if (pwrite_i)
					begin
						next_pslverr = (hit_kind == gpio_data_pkg::KIND_INPUT_LEVEL);
					end
					else
					begin
						case (hit_kind)
							gpio_data_pkg::KIND_ENABLE:
								next_prdata = enable_all[hit_word*32 +: 32];
							gpio_data_pkg::KIND_DIRECTION:
								next_prdata = direction_all[hit_word*32 +: 32];
							gpio_data_pkg::KIND_OUTPUT_LEVEL:
								next_prdata = output_level_all[hit_word*32 +: 32];
							gpio_data_pkg::KIND_INPUT_LEVEL:
								next_prdata = input_level_all[hit_word*32 +: 32];
							default:
								next_prdata = gpio_data_pkg::UNMAPPED_READ;
						endcase
					end
				end
			end
			gpio_data_pkg::ST_ACCESS:
			begin
				// master that drops psel mid-transfer also ends it
				next_state = gpio_data_pkg::ST_IDLE;
				next_prdata = gpio_data_pkg::UNMAPPED_READ;
			end
			default:
			begin
				next_state = gpio_data_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state <= gpio_data_pkg::ST_IDLE;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= gpio_data_pkg::UNMAPPED_READ;
		end
		else
		begin
			state <= next_state;
			pready_o <= next_pready;
			pslverr_o <= next_pslverr;
			prdata_o <= next_prdata;
		end
	end

endmodule // gpio_data_port

// ===== dv/gpio_data_port_properties.sv
/* checker for the pin data port: bus timing, error answers, pin gating
   assumes it is bound to gpio_data_port, one clock, async low reset */
`timescale 1ns/1ns
module gpio_data_port_properties #(
	parameter int NUM_WORDS = 3
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [31:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [NUM_WORDS*32-1:0] pin_out_o,
	input wire logic [NUM_WORDS*32-1:0] pin_oe_o,
	input wire logic [NUM_WORDS*32-1:0] pin_sel_o
);
	wire wr_done = psel_i && penable_i && pwrite_i && pready_o;
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);
	sequence setup_s;
		psel_i && !penable_i;
	endsequence
	sequence access_s;
		setup_s ##1 pready_o;
	endsequence
	ready_next_a: assert property (setup_s |=> pready_o)
		else $error("no ready after setup");
	ready_single_a: assert property (access_s |=> !pready_o)
		else $error("ready held too long");
	ready_cause_a: assert property (pready_o |-> $past(psel_i && !penable_i))
		else $error("ready without setup");
	rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
		else $error("read data outside access");
	err_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	ro_write_err_a: assert property (setup_s ##0 (pwrite_i && paddr_i >= 32'hD00A0024
		&& paddr_i <= 32'hD00A002C) |=> pslverr_o)
		else $error("input word write accepted");
	mapped_ok_a: assert property (setup_s ##0 (paddr_i <= 32'hD00A0020 && paddr_i[1:0] == 2'h0
		&& paddr_i >= 32'hD00A0000) |=> !pslverr_o)
		else $error("error on mapped word");
	drive_gate_a: assert property (!(|(pin_oe_o & ~pin_sel_o)))
		else $error("pin driven while not enabled");
	pins_still_a: assert property (!$past(wr_done) && !$past(wr_done, 2) |-> $stable(pin_out_o))
		else $error("pin level moved without write");
endmodule // gpio_data_port_properties

// ===== dv/gpio_pin_model.sv
/* far-side pin model: driven pins read back their own level, others the outside world
   assumes the bench changes ext_i only between bus transfers */
`timescale 1ns/1ns
module gpio_pin_model (
	input wire logic [95:0] pin_out_i,
	input wire logic [95:0] pin_oe_i,
	input wire logic [95:0] ext_i,
	output logic [95:0] pin_lvl_o
);
	// no pulls here, so undriven pins follow a random outside level
	assign pin_lvl_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_i);
endmodule // gpio_pin_model

// ===== dv/tb_gpio_output_input_data.sv
/* bench for the pin data port: APB tasks, register model, random rounds
   assumes gpio_pin_model on the pins and one 100 MHz clock */
`timescale 1ns/1ns
module tb_gpio_output_input_data;
	logic core_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [31:0] paddr_i = 32'h0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [31:0] pwdata_i = 32'h0;
	logic [3:0] pstrb_i = 4'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic [95:0] pin_in_i;
	logic [95:0] pin_out_o;
	logic [95:0] pin_oe_o;
	logic [95:0] pin_sel_o;
	logic [95:0] ext = 96'h0;
	logic [31:0] regs [0:8];
	logic [31:0] rd;
	logic err;
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int seed = 66780;
	int k;
	int w;
	gpio_data_port u_gpio_data_port (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
		.paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
		.pin_oe_o(pin_oe_o), .pin_sel_o(pin_sel_o));
	gpio_pin_model u_gpio_pin_model (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
		.ext_i(ext), .pin_lvl_o(pin_in_i));
	initial
	begin
		forever #5 core_clk_i = ~core_clk_i;
	end
	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge core_clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc > 3000)
		begin
			err_count++;
			wrap_up();
		end
	end
	task chk(input string n, input logic [95:0] seen, input logic [95:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch %s exp %h seen %h", n, exp, seen);
		end
	endtask
	// request held until pready seen, released only by the next call or idle
	task apb(input logic wr, input int i, input logic [31:0] wd, input logic [3:0] st);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= gpio_data_pkg::ENABLE_ADDR0 + 32'(i * 4);
		pwdata_i <= wd;
		pstrb_i <= st;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		// answer taken at the completing rising edge, before it updates
		@(posedge core_clk_i);
		while (pready_o !== 1'b1)
			@(posedge core_clk_i);
		rd = prdata_o;
		err = pslverr_o;
	endtask
	function automatic logic [31:0] exp_rd(int i);
		if (i < 9)
			return regs[i];
		if (i < 12)
			return (regs[i - 6] & ext[(i - 9) * 32 +: 32]) | (~regs[i - 6] & regs[i - 3]);
		return 32'h0;
	endfunction
	task wr(input int i, input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, i, d, s);
		chk("wr_err", 96'(err), 96'(i > 8));
		for (int b = 0; b < 4; b++)
			if (i < 9 && s[b])
				regs[i][b * 8 +: 8] = d[b * 8 +: 8];
	endtask
	task idle;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		ext <= {$random(seed), $random(seed), $random(seed)};
		repeat (2) @(posedge core_clk_i);
		@(negedge core_clk_i);
		chk("pin_out", pin_out_o, {regs[8], regs[7], regs[6]});
		chk("pin_oe", pin_oe_o, {regs[2], regs[1], regs[0]} & ~{regs[5], regs[4], regs[3]});
		chk("pin_sel", pin_sel_o, {regs[2], regs[1], regs[0]});
		@(posedge core_clk_i);
	endtask
	initial
	begin
		for (k = 0; k < 9; k++)
			regs[k] = (k > 2 && k < 6) ? 32'hFFFFFFFF : 32'h0;
		repeat (16) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		@(posedge core_clk_i);
		for (k = 0; k < 13; k++)
		begin
			apb(1'b0, k, 32'h0, 4'h0);
			chk("reset", 96'(rd), 96'(exp_rd(k)));
		end
		// direction and level first, enable last
		wr(3, 32'h0000FFFF, 4'hF);
		wr(6, 32'h00A5005A, 4'hF);
		wr(0, 32'h000000FF, 4'hF);
		for (k = 0; k < 200; k++)
		begin
			idle();
			w = $unsigned($random(seed)) % 13;
			apb(1'b0, w, 32'h0, 4'h0);
			chk("rd", 96'(rd), 96'(exp_rd(w)));
			chk("rd_err", 96'(err), 96'(w == 12));
			wr($unsigned($random(seed)) % 13, $random(seed), 4'($random(seed)));
		end
		idle();
		wrap_up();
	end
endmodule // tb_gpio_output_input_data
bind gpio_data_port gpio_data_port_properties #(.NUM_WORDS(NUM_WORDS)) u_props (
	.core_clk_i(core_clk_i), .nrst_i(nrst_i), .paddr_i(paddr_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pin_sel_o(pin_sel_o));
